// >>> tb/ffc_host_model.sv
// Host model: byte register accesses as issued by the serial front end
`timescale 1ns/1ps
module ffc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output ffc_pkg::ffc_req_t req_o
);
    import ffc_pkg::*;
    initial req_o = '0;
    // Released address and data show the inverse of the last value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        v = rvalid_i;
        d = rdata_i;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask : read_reg
endmodule : ffc_host_model

// >>> tb/ffc_regs_chk.sv
// Checker: port-level properties of the fan fault register bank
`timescale 1ns/1ps
module ffc_regs_chk #(
    parameter int unsigned NUM_FANS = 6,
    parameter int unsigned NUM_TACH = 12
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire ffc_pkg::ffc_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [NUM_TACH-1:0] detect_i,
    input wire ffc_pkg::ffc_setup_t [NUM_FANS-1:0] setup_o,
    input wire logic [NUM_FANS-1:0] asym_en_o,
    input wire logic [NUM_FANS-1:0][7:0] slew_o,
    input wire ffc_pkg::ffc_drive_t [NUM_FANS-1:0] drive_o,
    input wire logic [NUM_FANS-1:0] started_o,
    input wire logic any_fault_o
);
    import ffc_pkg::*;
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [NUM_FANS-1:0] asym_w;
    logic drive_any_w;
    always_comb begin
        drive_any_w = 1'b0;
        for (int i = 0; i < NUM_FANS; i++) begin
            asym_w[i] = slew_o[i][SLEW_ASYM_BIT];
            drive_any_w = drive_any_w | (drive_o[i] != FFC_DRIVE_NORMAL);
        end
    end
    rd_answer_a: assert property (ce_i && req_i.rd |=> rvalid_o)
        else $error("read not answered next cycle");
    rd_source_a: assert property (rvalid_o && $past(ce_i) |-> $past(req_i.rd))
        else $error("read valid without a read");
    rdata_hold_a: assert property (!(ce_i && req_i.rd) |=> $stable(rdata_o))
        else $error("read data changed without a read");
    ce_freeze_a: assert property (!ce_i |=> $stable(slew_o) && $stable(started_o))
        else $error("state moved while clock enable low");
    asym_copy_a: assert property ($past(ce_i) |-> asym_en_o == $past(asym_w))
        else $error("asymmetric enable differs from slew bit two");
    setup_low_a: assert property ({setup_o[2][3:0], setup_o[1][3:0], setup_o[0][3:0]} == 12'h000)
        else $error("fans one to three carry more than mode");
    drive_cause_a: assert property (drive_any_w |-> any_fault_o)
        else $error("failure drive without unmasked fault");
    start_order_a: assert property (((started_o >> 1) & ~started_o) == '0)
        else $error("fan started before its predecessor");
    start_keep_a: assert property ($past(nrst_i) |-> ($past(started_o) & ~started_o) == '0)
        else $error("started fan fell back");
    fault_rise_a: assert property ($rose(any_fault_o) |->
        ($past(detect_i, 2) != '0) || $past(req_i.wr) || $past(req_i.wr, 2))
        else $error("fault raised without detection or write");
    rd_seen_c: cover property (ce_i && req_i.rd);
    fault_seen_c: cover property ($rose(any_fault_o));
    all_start_c: cover property (&started_o);
    freeze_seen_c: cover property (!ce_i && req_i.wr);
endmodule : ffc_regs_chk

bind ffc_regs ffc_regs_chk #(.NUM_FANS(NUM_FANS), .NUM_TACH(NUM_TACH)) ffc_regs_chk_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .detect_i(detect_i), .setup_o(setup_o), .asym_en_o(asym_en_o),
    .slew_o(slew_o), .drive_o(drive_o), .started_o(started_o), .any_fault_o(any_fault_o)
);

// >>> tb/tb_fan_fault_config_regs.sv
// Testbench: register map, fault flags, failure response and start sequencing
`timescale 1ns/1ps
module tb_fan_fault_config_regs;
    import ffc_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic [11:0] detect_i = '0;
    logic [11:0] good_i = '0;
    logic count_load_i = 1'b0;
    logic [10:0] count1_i = '0;
    logic [2:0] fan123_i = 3'h5;
    ffc_req_t req_w;
    logic [7:0] rdata_w;
    logic rvalid_w;
    ffc_setup_t [5:0] setup_w;
    logic [5:0] asym_w;
    logic [5:0][7:0] slew_w;
    ffc_drive_t [5:0] drive_w;
    logic [5:0] started_w;
    logic any_fault_w;
    int n_mismatch = 0;
    int checks_done = 0;
    always #4 clk_i = ~clk_i;
    ffc_regs #(.CLK_KHZ(1)) ffc_regs_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_w), .rdata_o(rdata_w),
        .rvalid_o(rvalid_w), .detect_i(detect_i), .good_i(good_i), .count_load_i(count_load_i),
        .count1_i(count1_i), .fan123_setup_hi_i(fan123_i), .setup_o(setup_w),
        .asym_en_o(asym_w), .slew_o(slew_w), .drive_o(drive_w), .started_o(started_w),
        .any_fault_o(any_fault_w));
    ffc_host_model ffc_host_model_inst (
        .clk_i(clk_i), .rdata_i(rdata_w), .rvalid_i(rvalid_w), .req_o(req_w));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        ffc_host_model_inst.read_reg(a, d, v);
        check(v, 1'b1);
        check(d, e);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ffc_host_model_inst.write_reg(a, d);
    endtask : wr
    task automatic pulse(input logic [11:0] d, input logic [11:0] g);
        @(negedge clk_i);
        detect_i = d;
        good_i = g;
        @(negedge clk_i);
        detect_i = '0;
        good_i = '0;
    endtask : pulse
    task automatic do_reset();
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
    endtask : do_reset
    function automatic logic [7:0] rst_of(input logic [7:0] a);
        case (a) inside
            [8'h05:8'h07]: return RST_SETUP;
            [8'h08:8'h0D]: return RST_SLEW;
            8'h10, 8'h11: return RST_FLAGS;
            8'h12, 8'h13: return RST_IGNORE;
            8'h14: return RST_POLICY;
            8'h18: return 8'hFF;
            8'h19: return 8'hE0;
            default: return 8'h00;
        endcase
    endfunction : rst_of
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(asym_w, 6'h3F);
        check(slew_w[5], 8'h4C);
        check(drive_w, 12'h000);
        check(started_w, 6'h00);
        for (int a = 3; a <= 33; a++) rd_chk(a[7:0], rst_of(a[7:0]));
        check(setup_w[2:0], 15'h4010);
        rd_chk(8'hFF, 8'h00);
    endtask : t_reset
    task automatic t_seq();
        int t[6] = '{default: 0};
        logic ok;
        do_reset();
        wr(ADDR_POLICY, 8'h25);
        for (int c = 1; c < 3000; c++) begin
            @(negedge clk_i);
            for (int b = 1; b < 6; b++) if (started_w[b] && t[b] == 0) t[b] = c;
        end
        check(started_w, 6'h3F);
        for (int b = 2; b < 6; b++) begin
            ok = (t[b] - t[b-1] == 250);
            check(ok, 1'b1);
        end
        do_reset();
        wr(ADDR_POLICY, 8'h05);
        repeat (20) @(negedge clk_i);
        check(started_w, 6'h3F);
    endtask : t_seq
    task automatic t_rw();
        for (int a = 5; a <= 8'h17; a++) begin
            if (a inside {[16:20]}) continue;
            wr(a[7:0], 8'hFF);
            rd_chk(a[7:0], a < 8 ? MASK_SETUP : (a < 14 ? MASK_SLEW : 8'hFF));
        end
        check(setup_w[5:3], 15'h7FFF);
        check(slew_w[5], 8'hFC);
        wr(ADDR_SLEW_BASE, 8'h00);
        wr(ADDR_FAN4_SETUP, 8'h81);
        check(asym_w, 6'h3E);
        @(negedge clk_i);
        check(setup_w[3], 5'h11);
        wr(ADDR_IGNORE_HIGH, 8'hFF);
        rd_chk(ADDR_IGNORE_HIGH, 8'h3F);
        wr(ADDR_POLICY, 8'hFF);
        rd_chk(ADDR_POLICY, 8'hEF);
        wr(ADDR_POLICY, 8'h05);
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        wr(ADDR_COUNT1_UPPER, 8'h00);
        rd_chk(ADDR_COUNT1_UPPER, 8'hFF);
        @(negedge clk_i);
        count1_i = 11'h5A3;
        count_load_i = 1'b1;
        @(negedge clk_i);
        count_load_i = 1'b0;
        rd_chk(ADDR_COUNT1_UPPER, 8'hB4);
        rd_chk(ADDR_COUNT1_LOWER, 8'h60);
    endtask : t_rw
    task automatic t_queue();
        int n[4] = '{1, 2, 4, 6};
        for (int q = 0; q < 4; q++) begin
            wr(ADDR_POLICY, {6'h01, q[1:0]});
            pulse(12'h000, 12'hFFF);
            if (q == 1) pulse(12'h041, 12'h000);
            if (q == 1) pulse(12'h000, 12'h041);
            repeat (n[q] - 1) pulse(12'h041, 12'h000);
            rd_chk(ADDR_FLAGS_LOW, 8'h00);
            pulse(12'h041, 12'h000);
            repeat (5) @(negedge clk_i);
            rd_chk(ADDR_FLAGS_LOW, 8'h01);
            rd_chk(ADDR_FLAGS_HIGH, 8'h01);
            check(any_fault_w, 1'b0);
            wr(ADDR_FLAGS_LOW, 8'h00);
            wr(ADDR_FLAGS_HIGH, 8'h00);
            rd_chk(ADDR_FLAGS_HIGH, 8'h00);
        end
    endtask : t_queue
    task automatic t_resp();
        logic [11:0] e[4] = '{12'h001, 12'h000, 12'h002, 12'hAAA};
        wr(ADDR_IGNORE_LOW, 8'h3E);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_POLICY, {4'h0, r[1:0], 2'h0});
            pulse(12'h000, 12'hFFF);
            pulse(12'h001, 12'h000);
            @(negedge clk_i);
            check(any_fault_w, 1'b1);
            check(drive_w, e[r]);
            wr(ADDR_FLAGS_LOW, 8'h00);
            @(negedge clk_i);
            check(any_fault_w, 1'b0);
            check(drive_w, 12'h000);
        end
    endtask : t_resp
    task automatic t_freeze();
        @(negedge clk_i);
        ce_i = 1'b0;
        wr(ADDR_SCRATCH_C, 8'h5A);
        ce_i = 1'b1;
        rd_chk(ADDR_SCRATCH_C, 8'hFF);
        wr(ADDR_SCRATCH_C, 8'h5A);
        rd_chk(ADDR_SCRATCH_C, 8'h5A);
    endtask : t_freeze
    initial begin
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_seq();
        t_rw();
        t_queue();
        t_resp();
        t_freeze();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        close_out();
    end
endmodule : tb_fan_fault_config_regs

// >>> verilog/ffc_fault_queue.sv
// Per-channel fault detection counter that qualifies a fault after N detections
`timescale 1ns/1ps
module ffc_fault_queue #(
    parameter int unsigned CW = 3
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic detect_i,
    input wire logic good_i,
    input wire logic [CW-1:0] need_i,
    output logic fault_o
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic hit;

    initial begin
        if (CW < 3) begin
            $error("ffc_fault_queue: CW too small");
        end
    end

    assign hit = detect_i && ((cnt_q + CW'(1)) >= need_i);
    assign cnt_d = good_i ? '0 : (detect_i && !hit) ? cnt_q + CW'(1) : hit ? '0 : cnt_q;
    assign fault_o = en_i && hit;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (en_i) begin
            cnt_q <= cnt_d;
        end
    end
endmodule : ffc_fault_queue

// >>> verilog/ffc_pkg.sv
// Package: register map, field layout and reset values of the fan fault register bank
package ffc_pkg;
    localparam int unsigned NUM_FANS = 6;
    localparam int unsigned NUM_TACH = 12;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 11;

    localparam logic [7:0] ADDR_FAN4_SETUP = 8'h05;
    localparam logic [7:0] ADDR_FAN5_SETUP = 8'h06;
    localparam logic [7:0] ADDR_FAN6_SETUP = 8'h07;
    localparam logic [7:0] ADDR_SLEW_BASE = 8'h08;
    localparam logic [7:0] ADDR_SCRATCH_A = 8'h0E;
    localparam logic [7:0] ADDR_SCRATCH_B = 8'h0F;
    localparam logic [7:0] ADDR_FLAGS_HIGH = 8'h10;
    localparam logic [7:0] ADDR_FLAGS_LOW = 8'h11;
    localparam logic [7:0] ADDR_IGNORE_HIGH = 8'h12;
    localparam logic [7:0] ADDR_IGNORE_LOW = 8'h13;
    localparam logic [7:0] ADDR_POLICY = 8'h14;
    localparam logic [7:0] ADDR_SCRATCH_C = 8'h15;
    localparam logic [7:0] ADDR_SCRATCH_D = 8'h16;
    localparam logic [7:0] ADDR_SCRATCH_E = 8'h17;
    localparam logic [7:0] ADDR_COUNT1_UPPER = 8'h18;
    localparam logic [7:0] ADDR_COUNT1_LOWER = 8'h19;

    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [7:0] RST_SLEW = 8'h4C;
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_IGNORE = 8'h3F;
    localparam logic [7:0] RST_POLICY = 8'h45;
    localparam logic [10:0] RST_COUNT = 11'h7FF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam logic [7:0] MASK_SETUP = 8'h8F;
    localparam logic [7:0] MASK_SLEW = 8'hFC;
    localparam logic [7:0] MASK_CHAN6 = 8'h3F;
    localparam logic [7:0] MASK_POLICY = 8'hEF;

    localparam int unsigned SETUP_MODE_BIT = 7;
    localparam int unsigned SETUP_TACH_EN_BIT = 3;
    localparam int unsigned SETUP_LOCKED_BIT = 2;
    localparam int unsigned SETUP_LOCK_POL_BIT = 1;
    localparam int unsigned SETUP_PIN_TACH_BIT = 0;
    localparam int unsigned SLEW_ASYM_BIT = 2;
    localparam int unsigned POLICY_QUEUE_LSB = 0;
    localparam int unsigned POLICY_RESP_LSB = 2;
    localparam int unsigned POLICY_SEQ_LSB = 5;

    localparam logic [1:0] RESP_ZERO = 2'h0;
    localparam logic [1:0] RESP_CONTINUE = 2'h1;
    localparam logic [1:0] RESP_FULL = 2'h2;
    localparam logic [1:0] RESP_ALL_FULL = 2'h3;

    localparam logic [2:0] QUEUE_1 = 3'h1;
    localparam logic [2:0] QUEUE_2 = 3'h2;
    localparam logic [2:0] QUEUE_4 = 3'h4;
    localparam logic [2:0] QUEUE_6 = 3'h6;

    localparam int unsigned SEQ_MS_1 = 250;
    localparam int unsigned SEQ_MS_2 = 500;
    localparam int unsigned SEQ_MS_3 = 1000;
    localparam int unsigned SEQ_MS_4 = 2000;

    typedef struct packed {
        logic mode_rpm;
        logic tach_en;
        logic locked_rotor;
        logic lock_pol_high;
        logic pin_is_tach;
    } ffc_setup_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffc_req_t;

    typedef enum logic [1:0] {
        FFC_DRIVE_NORMAL,
        FFC_DRIVE_ZERO,
        FFC_DRIVE_FULL
    } ffc_drive_t;
endpackage : ffc_pkg

// >>> verilog/ffc_regs.sv
// Fan configuration, dynamics, fault status, mask and policy register bank
`timescale 1ns/1ps
// Notes on behaviour
// - Fan four to six setup registers share fan one layout, each steers own channel.
// - Slew registers hold asymmetric rate enable on bit two, reset to 4C.
// - Twelve sticky fault flags, channels 1-6 low register, 7-12 high register.
// - Per-channel ignore bits, set at reset, block the failed fan response.
// - Two-bit policy picks zero, continue, full, or all full on failure.
// - Fault reported only after 1, 2, 4 or 6 detections per channel.
// - Three-bit code sets start-up spacing 0, 250ms, 500ms, 1s, 2s.
// - Setup holds mode, tach enable, locked rotor, polarity, pin role bits.
// - Eleven-bit count, upper byte bits 10-3, lower byte bits 2-0 high, resets ones.
// - Scratch bytes store anything, steer nothing, reset to zero.
module ffc_regs #(
    parameter int unsigned NUM_FANS = 6,
    parameter int unsigned NUM_TACH = 12,
    parameter int unsigned CLK_KHZ = 125000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire ffc_pkg::ffc_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire logic [NUM_TACH-1:0] detect_i,
    input wire logic [NUM_TACH-1:0] good_i,
    input wire logic count_load_i,
    input wire logic [10:0] count1_i,
    input wire logic [2:0] fan123_setup_hi_i,
    output ffc_pkg::ffc_setup_t [NUM_FANS-1:0] setup_o,
    output logic [NUM_FANS-1:0] asym_en_o,
    output logic [NUM_FANS-1:0][7:0] slew_o,
    output ffc_pkg::ffc_drive_t [NUM_FANS-1:0] drive_o,
    output logic [NUM_FANS-1:0] started_o,
    output logic any_fault_o
);
    import ffc_pkg::*;

    initial begin
        if (NUM_FANS != 6 || NUM_TACH != 12) begin
            $error("ffc_regs: register map serves six fans and twelve tachometers");
        end
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [2:0][7:0] setup_hi_q;
    logic [NUM_FANS-1:0][7:0] slew_q;
    logic [4:0][7:0] scratch_q;
    logic [NUM_TACH-1:0] flags_q;
    logic [NUM_TACH-1:0] ignore_q;
    logic [7:0] policy_q;
    logic [10:0] count1_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    ffc_setup_t [NUM_FANS-1:0] setup_q;
    logic [NUM_FANS-1:0] asym_q;
    ffc_drive_t [NUM_FANS-1:0] drive_q;
    logic any_fault_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire wr = req_i.wr;
    wire [7:0] a = req_i.addr;
    wire [7:0] wd = req_i.wdata;
    wire wr_flags_hi = wr && (a == ADDR_FLAGS_HIGH);
    wire wr_flags_lo = wr && (a == ADDR_FLAGS_LOW);
    wire wr_ign_hi = wr && (a == ADDR_IGNORE_HIGH);
    wire wr_ign_lo = wr && (a == ADDR_IGNORE_LOW);
    wire wr_policy = wr && (a == ADDR_POLICY);
    wire [1:0] resp_code = policy_q[POLICY_RESP_LSB +: 2];
    wire [1:0] queue_code = policy_q[POLICY_QUEUE_LSB +: 2];
    wire [2:0] seq_code = policy_q[POLICY_SEQ_LSB +: 3];

    wire [2:0] need = (queue_code == 2'h0) ? QUEUE_1 :
                      (queue_code == 2'h1) ? QUEUE_2 :
                      (queue_code == 2'h2) ? QUEUE_4 : QUEUE_6;

    // ------------------------------------------------------------------
    // Fault qualification per channel
    // ------------------------------------------------------------------
    logic [NUM_TACH-1:0] qual;
    logic [NUM_TACH-1:0] clr_mask;
    logic [NUM_TACH-1:0] flags_d;

    genvar g;
    generate
        for (g = 0; g < NUM_TACH; g++) begin : g_chan
            ffc_fault_queue #(
                .CW(3)
            ) u_q (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .en_i(ce_i),
                .detect_i(detect_i[g]),
                .good_i(good_i[g]),
                .need_i(need),
                .fault_o(qual[g])
            );
            if (g < 6) begin : g_lo
                assign clr_mask[g] = wr_flags_lo && !wd[g];
            end else begin : g_hi
                assign clr_mask[g] = wr_flags_hi && !wd[g-6];
            end
            assign flags_d[g] = qual[g] | (flags_q[g] & !clr_mask[g]);
        end
    endgenerate

    wire [NUM_TACH-1:0] live_fault = flags_q & ~ignore_q;
    // all fans full on any unmasked fault when the policy selects all full
    wire all_full = (resp_code == RESP_ALL_FULL) && (|live_fault);

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            setup_hi_q <= {3{RST_SETUP}};
            scratch_q <= {5{RST_SCRATCH}};
            flags_q <= '0;
            ignore_q <= '1;
            policy_q <= RST_POLICY;
        end else if (ce_i) begin
            flags_q <= flags_d;
            if (wr && a == ADDR_FAN4_SETUP) begin
                setup_hi_q[0] <= wd & MASK_SETUP;
            end
            if (wr && a == ADDR_FAN5_SETUP) begin
                setup_hi_q[1] <= wd & MASK_SETUP;
            end
            if (wr && a == ADDR_FAN6_SETUP) begin
                setup_hi_q[2] <= wd & MASK_SETUP;
            end
            if (wr && a == ADDR_SCRATCH_A) begin
                scratch_q[0] <= wd;
            end
            if (wr && a == ADDR_SCRATCH_B) begin
                scratch_q[1] <= wd;
            end
            if (wr && a == ADDR_SCRATCH_C) begin
                scratch_q[2] <= wd;
            end
            if (wr && a == ADDR_SCRATCH_D) begin
                scratch_q[3] <= wd;
            end
            if (wr && a == ADDR_SCRATCH_E) begin
                scratch_q[4] <= wd;
            end
            if (wr_ign_lo) begin
                ignore_q[5:0] <= wd[5:0];
            end
            if (wr_ign_hi) begin
                ignore_q[11:6] <= wd[5:0];
            end
            if (wr_policy) begin
                policy_q <= wd & MASK_POLICY;
            end
        end
    end

    generate
        for (g = 0; g < NUM_FANS; g++) begin : g_slew
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    slew_q[g] <= RST_SLEW;
                end else if (ce_i && wr && a == ADDR_SLEW_BASE + 8'(g)) begin
                    slew_q[g] <= wd & MASK_SLEW;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            count1_q <= RST_COUNT;
        end else if (ce_i && count_load_i) begin
            count1_q <= count1_i;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = READ_UNMAPPED;
        case (a)
            ADDR_FAN4_SETUP: rd_mux = setup_hi_q[0];
            ADDR_FAN5_SETUP: rd_mux = setup_hi_q[1];
            ADDR_FAN6_SETUP: rd_mux = setup_hi_q[2];
            ADDR_SCRATCH_A: rd_mux = scratch_q[0];
            ADDR_SCRATCH_B: rd_mux = scratch_q[1];
            ADDR_FLAGS_HIGH: rd_mux = {2'b00, flags_q[11:6]};
            ADDR_FLAGS_LOW: rd_mux = {2'b00, flags_q[5:0]};
            ADDR_IGNORE_HIGH: rd_mux = {2'b00, ignore_q[11:6]};
            ADDR_IGNORE_LOW: rd_mux = {2'b00, ignore_q[5:0]};
            ADDR_POLICY: rd_mux = policy_q;
            ADDR_SCRATCH_C: rd_mux = scratch_q[2];
            ADDR_SCRATCH_D: rd_mux = scratch_q[3];
            ADDR_SCRATCH_E: rd_mux = scratch_q[4];
            ADDR_COUNT1_UPPER: rd_mux = count1_q[10:3];
            ADDR_COUNT1_LOWER: rd_mux = {count1_q[2:0], 5'b00000};
            default: begin
                if (a >= ADDR_SLEW_BASE && a < ADDR_SLEW_BASE + 8'(NUM_FANS)) begin
                    rd_mux = slew_q[3'(a - ADDR_SLEW_BASE)];
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_q <= READ_UNMAPPED;
            rvalid_q <= 1'b0;
        end else if (ce_i) begin
            rvalid_q <= req_i.rd;
            if (req_i.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequential start
    // ------------------------------------------------------------------
    logic [NUM_FANS-1:0] started;
    ffc_seq_start #(
        .NF(NUM_FANS),
        .CLK_KHZ(CLK_KHZ),
        .MS_1(SEQ_MS_1),
        .MS_2(SEQ_MS_2),
        .MS_3(SEQ_MS_3),
        .MS_4(SEQ_MS_4)
    ) u_seq (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(ce_i),
        .code_i(seq_code),
        .started_o(started)
    );

    // ------------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------------
    logic [NUM_FANS-1:0][7:0] setup_raw;
    logic [NUM_FANS-1:0] started_q;
    assign setup_raw[0] = {fan123_setup_hi_i[0], 7'h00};
    assign setup_raw[1] = {fan123_setup_hi_i[1], 7'h00};
    assign setup_raw[2] = {fan123_setup_hi_i[2], 7'h00};
    assign setup_raw[3] = setup_hi_q[0];
    assign setup_raw[4] = setup_hi_q[1];
    assign setup_raw[5] = setup_hi_q[2];

    generate
        for (g = 0; g < NUM_FANS; g++) begin : g_out
            ffc_drive_t drv;
            assign drv = all_full ? FFC_DRIVE_FULL :
                         !live_fault[g] ? FFC_DRIVE_NORMAL :
                         (resp_code == RESP_ZERO) ? FFC_DRIVE_ZERO :
                         (resp_code == RESP_FULL) ? FFC_DRIVE_FULL : FFC_DRIVE_NORMAL;
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    setup_q[g] <= '0;
                    asym_q[g] <= 1'b1;
                    drive_q[g] <= FFC_DRIVE_NORMAL;
                    started_q[g] <= 1'b0;
                end else if (ce_i) begin
                    setup_q[g].mode_rpm <= setup_raw[g][SETUP_MODE_BIT];
                    setup_q[g].tach_en <= setup_raw[g][SETUP_TACH_EN_BIT];
                    setup_q[g].locked_rotor <= setup_raw[g][SETUP_LOCKED_BIT];
                    setup_q[g].lock_pol_high <= setup_raw[g][SETUP_LOCK_POL_BIT];
                    setup_q[g].pin_is_tach <= setup_raw[g][SETUP_PIN_TACH_BIT];
                    asym_q[g] <= slew_q[g][SLEW_ASYM_BIT];
                    drive_q[g] <= drv;
                    started_q[g] <= started[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            any_fault_q <= 1'b0;
        end else if (ce_i) begin
            any_fault_q <= |live_fault;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign setup_o = setup_q;
    assign asym_en_o = asym_q;
    assign slew_o = slew_q;
    assign drive_o = drive_q;
    assign started_o = started_q;
    assign any_fault_o = any_fault_q;
endmodule : ffc_regs

// >>> verilog/ffc_seq_start.sv
// Sequential start timer that releases fans one after another
`timescale 1ns/1ps
module ffc_seq_start #(
    parameter int unsigned NF = 6,
    parameter int unsigned CLK_KHZ = 125000,
    parameter int unsigned MS_1 = 250,
    parameter int unsigned MS_2 = 500,
    parameter int unsigned MS_3 = 1000,
    parameter int unsigned MS_4 = 2000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [2:0] code_i,
    output logic [NF-1:0] started_o
);
    localparam int unsigned TW = 32;
    localparam logic [TW-1:0] TICKS_1 = TW'(MS_1 * CLK_KHZ);
    localparam logic [TW-1:0] TICKS_2 = TW'(MS_2 * CLK_KHZ);
    localparam logic [TW-1:0] TICKS_3 = TW'(MS_3 * CLK_KHZ);
    localparam logic [TW-1:0] TICKS_4 = TW'(MS_4 * CLK_KHZ);

    logic [TW-1:0] tmr_q;
    logic [NF-1:0] started_q;
    logic [TW-1:0] delay;
    logic step;

    initial begin
        if (NF < 1 || NF > 12) begin
            $error("ffc_seq_start: NF out of range");
        end
    end

    assign delay = (code_i == 3'h1) ? TICKS_1 :
                   (code_i == 3'h2) ? TICKS_2 :
                   (code_i == 3'h3) ? TICKS_3 :
                   (code_i == 3'h4) ? TICKS_4 : '0;
    assign step = ((tmr_q + TW'(1)) >= delay);
    assign started_o = started_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tmr_q <= '0;
            started_q <= '0;
        end else if (en_i && !(&started_q)) begin
            if (step) begin
                tmr_q <= '0;
                started_q <= {started_q[NF-2:0], 1'b1};
            end else begin
                tmr_q <= tmr_q + TW'(1);
            end
        end
    end
endmodule : ffc_seq_start
